// ==== dlc_pkg.sv ====
// Purpose: shared constants and types for the list-capable dma channel
// Assumes: 32-bit register port, one outstanding master request at a time
// Notes: register offsets and field layout are local to this channel
package dlc_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFF_SRC = 8'h00;
  localparam logic [7:0] OFF_DST = 8'h04;
  localparam logic [7:0] OFF_TCR = 8'h08;
  localparam logic [7:0] OFF_CPP = 8'h0c;
  localparam logic [7:0] OFF_GCSR = 8'h10;
  localparam logic [7:0] OFF_ATTR = 8'h14;

  // control and status word layout
  localparam int G_GO = 0;
  localparam int G_CHAIN = 1;
  localparam int G_STOP_RQ = 2;
  localparam int G_HALT_RQ = 3;
  localparam int G_ACT = 4;
  localparam int G_FLAG_LSB = 8;
  localparam int G_EN_LSB = 16;
  localparam int NFLAG = 6;

  // flag and enable indices
  localparam int FLG_FIRST_PCI_FAULT = 0;
  localparam int FLG_SECOND_PCI_FAULT = 1;
  localparam int FLG_PROC_BUS_FAULT = 2;
  localparam int FLG_STOPPED = 3;
  localparam int FLG_PAUSED = 4;
  localparam int FLG_DONE = 5;

  // transfer control layout
  localparam int BC_W = 24;
  localparam int TCR_SRC_LSB = 24;
  localparam int TCR_DST_LSB = 26;
  localparam int TCR_END_LSB = 28;

  // packet pointer layout
  localparam int CPP_LAST = 0;
  localparam int CPP_NCP_LSB = 5;
  localparam logic [31:0] CPP_MASK = 32'hffff_ffe1;

  // attributes layout
  localparam int ATTR_W = 14;
  localparam int A_WTT_LSB = 0;
  localparam int A_RTT_LSB = 5;
  localparam int A_GBL = 10;
  localparam int A_CI = 11;
  localparam int A_LIST_LSB = 12;
  localparam logic [4:0] TT_WRITE = 5'h02;
  localparam logic [4:0] TT_READ = 5'h0a;
  localparam logic [ATTR_W-1:0] ATTR_RST = {4'h0, TT_READ, TT_WRITE};

  // port codes
  localparam logic [1:0] PORT_PB = 2'h0;
  localparam logic [1:0] PORT_PCI1 = 2'h1;
  localparam logic [1:0] PORT_PCI2 = 2'h2;

  // command packet word offsets
  localparam logic [31:0] PKT_SRC = 32'h04;
  localparam logic [31:0] PKT_DST = 32'h0c;
  localparam logic [31:0] PKT_TCR = 32'h14;
  localparam logic [31:0] PKT_CPP = 32'h1c;

  localparam logic [BC_W-1:0] BEAT_BYTES = 24'h4;

  typedef enum logic [2:0] {
    ST_IDLE, ST_F_REQ, ST_F_WAIT, ST_RD_REQ, ST_RD_WAIT, ST_WR_REQ, ST_WR_WAIT
  } dlc_state_t;

  typedef struct packed {
    logic write;
    logic [1:0] port;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [4:0] bus_transfer_type;
    logic global_snoop_attr;
    logic cache_inhibit_attr;
    logic [1:0] endian;
  } dlc_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } dlc_rsp_t;

endpackage

// ==== dlc_channel.sv ====
// Purpose: one dma channel, direct and linked-list modes
// Assumes: one master request outstanding; every request gets one answer
// Notes: moves one 32-bit word per read/write pair
// Behaviour
// - done flag sets on finish, write-one clears
// - six interrupt enables, all off at reset
// - default write type 00010, read 01010
// - global attribute driven from channel setting
// - cache-inhibit attribute driven from channel setting
// - launch write also takes mode and clears
// - direct moves until abort, error or zero
// - count reaching zero completes, sets done
// - address and count registers show live progress
// - abort drains buffered data, then sets stopped
// - trailing data after abort stays within 256 bytes
// - list mode fetches and runs packets itself
// - packets aligned; pci little, processor big endian
// - packets fetched from selected list port
// - packet loads address, control and pointer registers
// - address writes ignored while channel active
// - destination low bits follow source low bits
// - control selects buses, endian mode, byte count
// - pointer holds next address and last flag
// - packet words at 04, 0c, 14, 1c
// - lowest three destination bits copied from source
// - list done only after last packet finishes
// - pause finishes current packet, then sets paused
`timescale 1ns/1ns
module dlc_channel
  import dlc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // bus master port
  output logic mst_valid_o,
  output dlc_pkg::dlc_req_t mst_req_o,
  input wire logic mst_ready_i,
  input wire dlc_pkg::dlc_rsp_t mst_rsp_i,
  // status
  output logic irq_o,
  output logic active_o
);
  import dlc_pkg::*;

  typedef struct packed {
    dlc_state_t st;
    logic [31:0] source_address_reg;
    logic [31:0] destination_address_reg;
    logic [31:0] transfer_control_reg;
    logic [31:0] next_packet_pointer;
    logic [ATTR_W-1:0] channel_attributes_reg;
    logic [31:0] pkt_src;
    logic [31:0] pkt_dst;
    logic [31:0] pkt_tcr;
    logic [31:0] data_buf;
    logic [31:0] rdata;
    logic chain;
    logic stop_req;
    logic halt_req;
    logic [NFLAG-1:0] flags;
    logic [NFLAG-1:0] en;
    logic [1:0] widx;
    logic irq;
  } dlc_regs_t;

  dlc_regs_t q_ff;
  dlc_regs_t nxt_q;

  // bytes moved by one beat: a full word, or the tail of the count
  function automatic logic [BC_W-1:0] dlc_step(input logic [BC_W-1:0] bc);
    return (bc > BEAT_BYTES) ? BEAT_BYTES : bc;
  endfunction

  function automatic logic [NFLAG-1:0] dlc_fault(input logic [1:0] port);
    logic [NFLAG-1:0] f;
    f = '0;
    unique case (port)
      PORT_PB: f[FLG_PROC_BUS_FAULT] = 1'b1;
      PORT_PCI1: f[FLG_FIRST_PCI_FAULT] = 1'b1;
      default: f[FLG_SECOND_PCI_FAULT] = 1'b1;
    endcase
    return f;
  endfunction

  function automatic logic [31:0] dlc_bswap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  logic busy;
  logic [BC_W-1:0] bc;
  logic [BC_W-1:0] step;
  logic [1:0] list_port;
  logic [31:0] pkt_word;
  logic [31:0] pkt_off;
  logic [NFLAG-1:0] set_flags;
  logic [NFLAG-1:0] clr_flags;
  logic zero_hit;
  logic gcsr_wr;

  assign busy = (q_ff.st != ST_IDLE);
  assign bc = q_ff.transfer_control_reg[BC_W-1:0];
  assign step = dlc_step(bc);
  assign list_port = q_ff.channel_attributes_reg[A_LIST_LSB +: 2];
  assign gcsr_wr = reg_wr_i && (reg_addr_i == OFF_GCSR);
  // packet words arrive in pci lane order; processor memory is big endian
  assign pkt_word = (list_port == PORT_PB) ? dlc_bswap(mst_rsp_i.rdata)
                                           : mst_rsp_i.rdata;

  always_comb begin
    unique case (q_ff.widx)
      2'h0: pkt_off = PKT_SRC;
      2'h1: pkt_off = PKT_DST;
      2'h2: pkt_off = PKT_TCR;
      2'h3: pkt_off = PKT_CPP;
    endcase
  end

  always_comb begin
    nxt_q = q_ff;
    set_flags = '0;
    clr_flags = '0;
    zero_hit = 1'b0;
    mst_valid_o = 1'b0;
    mst_req_o = '0;
    mst_req_o.global_snoop_attr = q_ff.channel_attributes_reg[A_GBL];
    mst_req_o.cache_inhibit_attr = q_ff.channel_attributes_reg[A_CI];
    mst_req_o.endian = q_ff.transfer_control_reg[TCR_END_LSB +: 2];

    // register reads answer in the following cycle only
    nxt_q.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFF_SRC: nxt_q.rdata = q_ff.source_address_reg;
        OFF_DST: nxt_q.rdata = q_ff.destination_address_reg;
        OFF_TCR: nxt_q.rdata = q_ff.transfer_control_reg;
        OFF_CPP: nxt_q.rdata = q_ff.next_packet_pointer;
        OFF_ATTR: nxt_q.rdata[ATTR_W-1:0] = q_ff.channel_attributes_reg;
        OFF_GCSR: begin
          nxt_q.rdata[G_CHAIN] = q_ff.chain;
          nxt_q.rdata[G_STOP_RQ] = q_ff.stop_req;
          nxt_q.rdata[G_HALT_RQ] = q_ff.halt_req;
          nxt_q.rdata[G_ACT] = busy;
          nxt_q.rdata[G_FLAG_LSB +: NFLAG] = q_ff.flags;
          nxt_q.rdata[G_EN_LSB +: NFLAG] = q_ff.en;
        end
        default: nxt_q.rdata = '0;
      endcase
    end

    // register writes; most fields are locked while the channel runs
    if (reg_wr_i && !busy) begin
      unique case (reg_addr_i)
        OFF_SRC: begin
          nxt_q.source_address_reg = reg_wdata_i;
          nxt_q.destination_address_reg[2:0] = reg_wdata_i[2:0];
        end
        OFF_DST: nxt_q.destination_address_reg =
          {reg_wdata_i[31:3], q_ff.source_address_reg[2:0]};
        OFF_TCR: nxt_q.transfer_control_reg = reg_wdata_i;
        OFF_CPP: nxt_q.next_packet_pointer = reg_wdata_i & CPP_MASK;
        OFF_ATTR: nxt_q.channel_attributes_reg = reg_wdata_i[ATTR_W-1:0];
        OFF_GCSR: nxt_q.chain = reg_wdata_i[G_CHAIN];
        default: ;
      endcase
    end
    if (gcsr_wr) begin
      clr_flags = reg_wdata_i[G_FLAG_LSB +: NFLAG];
      nxt_q.en = reg_wdata_i[G_EN_LSB +: NFLAG];
      if (busy) begin
        // stop and pause requests stay writable while running
        nxt_q.stop_req = q_ff.stop_req | reg_wdata_i[G_STOP_RQ];
        nxt_q.halt_req = q_ff.halt_req | reg_wdata_i[G_HALT_RQ];
      end
    end

    unique case (q_ff.st)
      ST_IDLE: begin
        nxt_q.stop_req = 1'b0;
        nxt_q.halt_req = 1'b0;
        if (gcsr_wr && reg_wdata_i[G_GO]) begin
          // a non-zero count in list mode first drains as a direct run
          if (bc != '0) begin
            nxt_q.st = ST_RD_REQ;
          end else if (reg_wdata_i[G_CHAIN]) begin
            nxt_q.st = ST_F_REQ;
            nxt_q.widx = 2'h0;
          end else begin
            set_flags[FLG_DONE] = 1'b1;
          end
        end
      end
      ST_F_REQ: begin
        if (q_ff.stop_req) begin
          set_flags[FLG_STOPPED] = 1'b1;
          nxt_q.st = ST_IDLE;
        end else begin
          mst_valid_o = 1'b1;
          mst_req_o.port = list_port;
          mst_req_o.addr = {q_ff.next_packet_pointer[31:CPP_NCP_LSB], 5'h0}
                           + pkt_off;
          mst_req_o.bus_transfer_type =
            q_ff.channel_attributes_reg[A_RTT_LSB +: 5];
          if (mst_ready_i) begin
            nxt_q.st = ST_F_WAIT;
          end
        end
      end
      ST_F_WAIT: begin
        if (mst_rsp_i.valid) begin
          if (mst_rsp_i.err) begin
            // a failed fetch leaves the channel registers untouched
            set_flags = dlc_fault(list_port);
            nxt_q.st = ST_IDLE;
          end else begin
            nxt_q.widx = q_ff.widx + 2'h1;
            nxt_q.st = ST_F_REQ;
            unique case (q_ff.widx)
              2'h0: nxt_q.pkt_src = pkt_word;
              2'h1: nxt_q.pkt_dst = pkt_word;
              2'h2: nxt_q.pkt_tcr = pkt_word;
              2'h3: begin
                nxt_q.source_address_reg = q_ff.pkt_src;
                nxt_q.destination_address_reg =
                  {q_ff.pkt_dst[31:3], q_ff.pkt_src[2:0]};
                nxt_q.transfer_control_reg = q_ff.pkt_tcr;
                nxt_q.next_packet_pointer = pkt_word & CPP_MASK;
                if (q_ff.pkt_tcr[BC_W-1:0] != '0) begin
                  nxt_q.st = ST_RD_REQ;
                end else begin
                  nxt_q.st = ST_IDLE;
                  zero_hit = 1'b1;
                end
              end
            endcase
          end
        end
      end
      ST_RD_REQ: begin
        if (q_ff.stop_req) begin
          // nothing buffered yet, so the abort takes effect at once
          set_flags[FLG_STOPPED] = 1'b1;
          nxt_q.st = ST_IDLE;
        end else begin
          mst_valid_o = 1'b1;
          mst_req_o.port = q_ff.transfer_control_reg[TCR_SRC_LSB +: 2];
          mst_req_o.addr = q_ff.source_address_reg;
          mst_req_o.bus_transfer_type =
            q_ff.channel_attributes_reg[A_RTT_LSB +: 5];
          if (mst_ready_i) begin
            nxt_q.st = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        if (mst_rsp_i.valid) begin
          if (mst_rsp_i.err) begin
            set_flags = dlc_fault(
              q_ff.transfer_control_reg[TCR_SRC_LSB +: 2]);
            nxt_q.st = ST_IDLE;
          end else begin
            nxt_q.data_buf = mst_rsp_i.rdata;
            nxt_q.st = ST_WR_REQ;
          end
        end
      end
      ST_WR_REQ: begin
        // buffered data is written even when an abort is pending
        mst_valid_o = 1'b1;
        mst_req_o.write = 1'b1;
        mst_req_o.port = q_ff.transfer_control_reg[TCR_DST_LSB +: 2];
        mst_req_o.addr = q_ff.destination_address_reg;
        mst_req_o.wdata = q_ff.data_buf;
        mst_req_o.bus_transfer_type =
          q_ff.channel_attributes_reg[A_WTT_LSB +: 5];
        if (mst_ready_i) begin
          nxt_q.st = ST_WR_WAIT;
        end
      end
      ST_WR_WAIT: begin
        if (mst_rsp_i.valid) begin
          nxt_q.st = ST_IDLE;
          if (mst_rsp_i.err) begin
            set_flags = dlc_fault(
              q_ff.transfer_control_reg[TCR_DST_LSB +: 2]);
          end else begin
            // all three advance together so the low bits stay equal
            nxt_q.source_address_reg = q_ff.source_address_reg
                                       + {8'h0, step};
            nxt_q.destination_address_reg = q_ff.destination_address_reg
                                            + {8'h0, step};
            nxt_q.transfer_control_reg[BC_W-1:0] = bc - step;
            if (q_ff.stop_req) begin
              set_flags[FLG_STOPPED] = 1'b1;
            end else if (bc != step) begin
              nxt_q.st = ST_RD_REQ;
            end else begin
              zero_hit = 1'b1;
            end
          end
        end
      end
    endcase

    // end of a block: finish, pause, or fetch the next packet
    if (zero_hit) begin
      nxt_q.st = ST_IDLE;
      if (!q_ff.chain || nxt_q.next_packet_pointer[CPP_LAST]) begin
        set_flags[FLG_DONE] = 1'b1;
      end else if (q_ff.halt_req) begin
        set_flags[FLG_PAUSED] = 1'b1;
      end else begin
        nxt_q.st = ST_F_REQ;
        nxt_q.widx = 2'h0;
      end
    end

    // a hardware set wins over a clear in the same cycle
    nxt_q.flags = (q_ff.flags & ~clr_flags) | set_flags;
    nxt_q.irq = |(nxt_q.flags & nxt_q.en);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q_ff <= '0;
      q_ff.st <= ST_IDLE;
      q_ff.channel_attributes_reg <= ATTR_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata_o = q_ff.rdata;
  assign irq_o = q_ff.irq;
  assign active_o = busy;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  done_direct_a: assert property (
    q_ff.st == ST_WR_WAIT && mst_rsp_i.valid && !mst_rsp_i.err &&
    !q_ff.stop_req && !q_ff.chain && bc == step
    |=> q_ff.flags[FLG_DONE] && q_ff.st == ST_IDLE)
    else $error("direct run ended without done");

  done_sticky_a: assert property (
    q_ff.flags[FLG_DONE] &&
    !(gcsr_wr && reg_wdata_i[G_FLAG_LSB + FLG_DONE])
    |=> q_ff.flags[FLG_DONE])
    else $error("done flag lost without a clear");

  irq_level_a: assert property (
    |(q_ff.flags & q_ff.en) |-> irq_o)
    else $error("enabled flag set but no interrupt");

  read_type_a: assert property (
    mst_valid_o && q_ff.st == ST_RD_REQ
    |-> !mst_req_o.write && mst_req_o.bus_transfer_type ==
        q_ff.channel_attributes_reg[A_RTT_LSB +: 5])
    else $error("data read with wrong transfer type");

  addr_lock_a: assert property (
    reg_wr_i && reg_addr_i == OFF_DST &&
    (q_ff.st == ST_RD_REQ || q_ff.st == ST_RD_WAIT || q_ff.st == ST_WR_REQ)
    |=> q_ff.destination_address_reg == $past(q_ff.destination_address_reg))
    else $error("destination changed by write while active");

  low_bits_a: assert property (
    q_ff.destination_address_reg[2:0] == q_ff.source_address_reg[2:0])
    else $error("destination low bits differ from source");

  abort_drain_a: assert property (
    q_ff.stop_req && q_ff.st == ST_RD_REQ
    |-> !mst_valid_o ##1 q_ff.flags[FLG_STOPPED] && !busy)
    else $error("abort did not stop the source side");

  fetch_first_a: assert property (
    q_ff.st == ST_F_REQ && q_ff.widx == 2'h0 && !q_ff.stop_req
    |-> mst_valid_o && mst_req_o.port == list_port &&
        mst_req_o.addr == {q_ff.next_packet_pointer[31:5], 5'h0} + PKT_SRC)
    else $error("packet fetch at wrong port or address");

  launch_list_a: assert property (
    !busy && gcsr_wr && reg_wdata_i[G_GO] && reg_wdata_i[G_CHAIN] &&
    bc == '0
    |=> q_ff.st == ST_F_REQ && q_ff.chain)
    else $error("launch with list mode did not fetch");

endmodule

// ==== dlc_mem_model.sv ====
// Purpose: memory targets behind the three master ports of the channel
// Assumes: one request outstanding, as the channel promises
// Notes: delay_i slows both accept and answer; err_en_i fails one address
`timescale 1ns/1ns
module dlc_mem_model
  import dlc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // channel master port
  input wire logic mst_valid_i,
  input wire dlc_pkg::dlc_req_t mst_req_i,
  output logic mst_ready_o,
  output dlc_pkg::dlc_rsp_t mst_rsp_o,
  // bench controls
  input wire logic [3:0] delay_i,
  input wire logic err_en_i,
  input wire logic [33:0] err_key_i
);
  logic [31:0] mem [logic [33:0]];
  dlc_req_t held_q;
  logic pend_q;
  logic [3:0] cnt_q;
  logic [33:0] key;
  logic bad;
  assign key = {held_q.port, held_q.addr};
  assign bad = err_en_i && key == err_key_i;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mst_ready_o <= 1'b0;
      mst_rsp_o <= '0;
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      mst_ready_o <= 1'b0;
      // idle data toggles so stale read data never looks valid
      mst_rsp_o <= {2'b00, ~mst_rsp_o.rdata};
      if (pend_q) begin
        if (cnt_q >= delay_i) begin
          pend_q <= 1'b0;
          cnt_q <= 4'h0;
          mst_rsp_o.valid <= 1'b1;
          mst_rsp_o.err <= bad;
          if (!held_q.write) begin
            mst_rsp_o.rdata <= mem.exists(key) ? mem[key] : ~held_q.addr;
          end else if (!bad) begin
            mem[key] = held_q.wdata;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (mst_valid_i && mst_ready_o) begin
        held_q <= mst_req_i;
        pend_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (mst_valid_i) begin
        if (cnt_q >= delay_i) begin
          mst_ready_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the dma channel
// Assumes: endian field left 0, so data words move unchanged
// Notes: flags are cleared on every launch write
`timescale 1ns/1ns
module tb_top;
  import dlc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [31:0] rdat, rv, attr_q;
  logic mv, mr, irq, active;
  dlc_req_t mq;
  dlc_rsp_t ms;
  logic [3:0] delay = 4'h0;
  logic err_en = 1'b0;
  logic [33:0] err_key = '0;
  logic [1:0] lport = 2'h3;
  int error_cnt = 0;
  int checks_done = 0;
  int n_rd, n_wr, n_f;
  always #50 clk_i = ~clk_i;
  dlc_channel dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(rwr), .reg_rd_i(rrd),
    .reg_rdata_o(rdat), .mst_valid_o(mv), .mst_req_o(mq),
    .mst_ready_i(mr), .mst_rsp_i(ms), .irq_o(irq), .active_o(active));
  dlc_mem_model mem_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .mst_valid_i(mv), .mst_req_i(mq), .mst_ready_o(mr), .mst_rsp_o(ms),
    .delay_i(delay), .err_en_i(err_en), .err_key_i(err_key));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(posedge clk_i) begin
    if (reset_n_i && mv && mr) begin
      if (mq.write) n_wr++;
      else if (mq.port == lport) n_f++;
      else n_rd++;
      if (!mq.write && mq.port == lport) chk(mq.addr[2:0], 3'h4);
      chk(mq.bus_transfer_type, mq.write ? TT_WRITE : TT_READ);
      chk({mq.global_snoop_attr, mq.cache_inhibit_attr},
          {attr_q[10], attr_q[11]});
      chk(mq.endian, 2'h0);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ra <= a;
    wd <= d;
    rwr <= 1'b1;
    @(posedge clk_i);
    rwr <= 1'b0;
    if (a == OFF_ATTR) attr_q = d;
    // one quiet edge so a following write never re-raises the strobe at once
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk_i);
    rrd <= 1'b0;
    @(negedge clk_i);
    rv = rdat;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask
  task automatic idle();
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk_i);
      if (active === 1'b0) break;
    end
    @(posedge clk_i);
    chk(active, 1'b0);
  endtask
  // processor-bus packets are stored byte-reversed, pci ones as is
  function automatic logic [31:0] sw(input logic [1:0] p, input logic [31:0] x);
    return p == PORT_PB ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
  endfunction
  task automatic pkt(input logic [1:0] p, input logic [31:0] b, s, d, t, c);
    mem_u.mem[{p, b + PKT_SRC}] = sw(p, s);
    mem_u.mem[{p, b + PKT_DST}] = sw(p, d);
    mem_u.mem[{p, b + PKT_TCR}] = sw(p, t);
    mem_u.mem[{p, b + PKT_CPP}] = sw(p, c);
  endtask
  task automatic t_reset();
    chk(irq, 1'b0);
    rc(OFF_GCSR, 32'h0);
    rc(OFF_ATTR, {18'h0, ATTR_RST});
    rc(8'h18, 32'h0);
    wr(OFF_SRC, 32'h103);
    wr(OFF_DST, 32'h200);
    rc(OFF_DST, 32'h203);
    $display("reset test done");
  endtask
  task automatic t_direct();
    mem_u.mem[{PORT_PB, 32'h100}] = 32'hcafe0001;
    mem_u.mem[{PORT_PB, 32'h104}] = 32'hcafe0002;
    wr(OFF_ATTR, {18'h0, ATTR_RST} | 32'hc00);
    wr(OFF_SRC, 32'h100);
    wr(OFF_TCR, 32'h0400_0008);
    wr(OFF_GCSR, 32'h0020_3f01);
    wr(OFF_SRC, 32'h999);
    idle();
    rc(OFF_SRC, 32'h108);
    rc(OFF_DST, 32'h208);
    rc(OFF_TCR, 32'h0400_0000);
    chk(mem_u.mem[{PORT_PCI1, 32'h200}], 32'hcafe0001);
    chk(mem_u.mem[{PORT_PCI1, 32'h204}], 32'hcafe0002);
    rc(OFF_GCSR, 32'h0020_2000);
    chk(irq, 1'b1);
    wr(OFF_GCSR, 32'h0020_2000);
    rc(OFF_GCSR, 32'h0020_0000);
    chk(irq, 1'b0);
    $display("direct test done");
  endtask
  task automatic t_abort();
    for (int i = 0; i < 16; i++) mem_u.mem[{PORT_PB, 32'h500 + 4 * i}] = 32'h5a00 + i;
    delay <= 4'h2;
    n_rd = 0;
    n_wr = 0;
    wr(OFF_SRC, 32'h500);
    wr(OFF_DST, 32'h600);
    wr(OFF_TCR, 32'h0400_0040);
    wr(OFF_GCSR, 32'h0028_3f01);
    repeat (20) @(posedge clk_i);
    wr(OFF_GCSR, 32'h0028_0004);
    idle();
    rd(OFF_TCR);
    chk(n_wr, n_rd);
    chk(32'h40 - rv[23:0] <= 256, 1'b1);
    chk(32'h40 - rv[23:0], 4 * n_wr);
    rc(OFF_GCSR, 32'h0028_0800);
    chk(irq, 1'b1);
    wr(OFF_GCSR, 32'h0028_3f01);
    idle();
    rc(OFF_GCSR, 32'h0028_2000);
    for (int i = 0; i < 16; i++)
      chk(mem_u.mem[{PORT_PCI1, 32'h600 + 4 * i}], 32'h5a00 + i);
    $display("abort test done");
  endtask
  task automatic t_error();
    err_en <= 1'b1;
    err_key <= {PORT_PB, 32'h704};
    wr(OFF_SRC, 32'h700);
    wr(OFF_TCR, 32'h0400_0008);
    wr(OFF_GCSR, 32'h0004_3f01);
    idle();
    rc(OFF_GCSR, 32'h0004_0400);
    chk(irq, 1'b1);
    wr(OFF_GCSR, 32'h0);
    rc(OFF_GCSR, 32'h0000_0400);
    chk(irq, 1'b0);
    err_en <= 1'b0;
    delay <= 4'h3;
    $display("error test done");
  endtask
  task automatic t_pause();
    mem_u.mem[{PORT_PB, 32'h300}] = 32'hbeef0001;
    mem_u.mem[{PORT_PB, 32'h304}] = 32'hbeef0002;
    pkt(PORT_PCI2, 32'h1000, 32'h300, 32'h400, 32'h0400_0004, 32'h1020);
    pkt(PORT_PCI2, 32'h1020, 32'h304, 32'h404, 32'h0400_0004, 32'h41);
    lport = PORT_PCI2;
    n_f = 0;
    wr(OFF_ATTR, {18'h0, ATTR_RST} | 32'h2000);
    wr(OFF_CPP, 32'h1000);
    wr(OFF_TCR, 32'h0);
    wr(OFF_GCSR, 32'h0030_3f03);
    wr(OFF_GCSR, 32'h0030_000a);
    idle();
    chk(n_f, 4);
    rc(OFF_GCSR, 32'h0030_1002);
    rc(OFF_CPP, 32'h1020);
    chk(mem_u.mem[{PORT_PCI1, 32'h400}], 32'hbeef0001);
    chk(mem_u.mem.exists({PORT_PCI1, 32'h404}), 0);
    wr(OFF_GCSR, 32'h0030_3f03);
    idle();
    chk(n_f, 8);
    rc(OFF_CPP, 32'h41);
    rc(OFF_SRC, 32'h308);
    rc(OFF_GCSR, 32'h0030_2002);
    chk(mem_u.mem[{PORT_PCI1, 32'h404}], 32'hbeef0002);
    $display("list pause test done");
  endtask
  task automatic t_pb();
    mem_u.mem[{PORT_PCI2, 32'h800}] = 32'h1234abcd;
    pkt(PORT_PB, 32'h2000, 32'h800, 32'h900, 32'h0200_0004, 32'h1);
    lport = PORT_PB;
    n_f = 0;
    wr(OFF_ATTR, {18'h0, ATTR_RST});
    wr(OFF_CPP, 32'h2000);
    wr(OFF_GCSR, 32'h0020_3f03);
    idle();
    chk(n_f, 4);
    rc(OFF_SRC, 32'h804);
    rc(OFF_TCR, 32'h0200_0000);
    chk(mem_u.mem[{PORT_PB, 32'h900}], 32'h1234abcd);
    rc(OFF_GCSR, 32'h0020_2002);
    $display("list pb test done");
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    attr_q = 32'h0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_direct();
    t_abort();
    t_error();
    t_pause();
    t_pb();
    end_sim();
  end
  // far above the few hundred cycles the tests need
  initial begin
    #(100 * 50000);
    error_cnt++;
    end_sim();
  end
endmodule
